// >>> core/asba_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - The controller sets the address before a write and holds it through the whole strobe overlap.
// - The controller keeps the output gate high during writes so the memory never drives while it does.
// - The controller never drives the data port while the memory drives it.
module asba_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire asba_pkg::asba_req_t req,
  output logic rd_valid,
  output logic [asba_pkg::ASBA_DW-1:0] rd_data,
  output logic wr_done,
  output asba_pkg::asba_pins_t pins,
  output logic [asba_pkg::ASBA_DW-1:0] dq_o,
  output logic dq_oe,
  input wire logic [asba_pkg::ASBA_DW-1:0] dq_i
);
  import asba_pkg::*;

  logic rst_meta_r;
  logic rst_sync_n;
  asba_state_t state_r;
  asba_state_t state_nxt;
  logic [ASBA_CW-1:0] cnt_r;
  logic [ASBA_CW-1:0] cnt_nxt;
  asba_pins_t pins_r;
  asba_pins_t pins_nxt;
  logic [ASBA_DW-1:0] dq_o_r;
  logic [ASBA_DW-1:0] dq_o_nxt;
  logic dq_oe_r;
  logic dq_oe_nxt;
  logic [ASBA_DW-1:0] rd_data_r;
  logic [ASBA_DW-1:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic wr_done_r;
  logic wr_done_nxt;
  logic [ASBA_DW-1:0] dq_sync;
  logic dq_stable;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  asba_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_sync_n),
    .din(dq_i),
    .dout(dq_sync),
    .stable(dq_stable)
  );

  assign req_ready = (state_r == ASBA_IDLE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    dq_o_nxt = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    wr_done_nxt = 1'b0;
    unique case (state_r)
      ASBA_IDLE: begin
        pins_nxt.s_n = 1'b1;
        pins_nxt.w_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        dq_oe_nxt = 1'b0;
        if (req_valid) begin
          // Address latched here and held until the next accept
          pins_nxt.addr = req.addr;
          pins_nxt.s_n = 1'b0;
          if (req.we) begin
            dq_o_nxt = req.wdata;
            state_nxt = ASBA_WSET;
          end else begin
            pins_nxt.oe_n = 1'b0;
            cnt_nxt = ASBA_RD_WAIT;
            state_nxt = ASBA_RACC;
          end
        end
      end
      ASBA_WSET: begin
        // Strobe falls after the enable with the output gate high
        pins_nxt.w_n = 1'b0;
        pins_nxt.oe_n = 1'b1;
        dq_oe_nxt = 1'b1;
        cnt_nxt = ASBA_WP_LOAD;
        state_nxt = ASBA_WPULSE;
      end
      ASBA_WPULSE: begin
        if (cnt_r == '0) begin
          // Strobe rises first, data still held for the latch edge
          pins_nxt.w_n = 1'b1;
          state_nxt = ASBA_WHOLD;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ASBA_WHOLD: begin
        pins_nxt.s_n = 1'b1;
        dq_oe_nxt = 1'b0;
        wr_done_nxt = 1'b1;
        state_nxt = ASBA_IDLE;
      end
      ASBA_RACC: begin
        if (cnt_r == '0) begin
          state_nxt = ASBA_RCAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ASBA_RCAP: begin
        if (dq_stable) begin
          rd_data_nxt = dq_sync;
          rd_valid_nxt = 1'b1;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.s_n = 1'b1;
          cnt_nxt = ASBA_DIS_LOAD;
          state_nxt = ASBA_TURN;
        end
      end
      ASBA_TURN: begin
        // Memory output still turning off; no new drive yet
        if (cnt_r == '0) begin
          state_nxt = ASBA_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = ASBA_IDLE;
        pins_nxt = ASBA_PINS_IDLE;
        dq_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= ASBA_IDLE;
      cnt_r <= '0;
      pins_r <= ASBA_PINS_IDLE;
      dq_o_r <= ASBA_DATA_RST;
      dq_oe_r <= 1'b0;
      rd_data_r <= ASBA_DATA_RST;
      rd_valid_r <= 1'b0;
      wr_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      dq_o_r <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      wr_done_r <= wr_done_nxt;
    end
  end

  assign pins = pins_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign wr_done = wr_done_r;

  addr_stable_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (!pins_r.s_n && !pins_r.w_n) |=> $stable(pins_r.addr))
    else $error("address moved during write overlap");

  addr_setup_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $fell(pins_r.w_n) |-> $stable(pins_r.addr) && !$past(pins_r.s_n))
    else $error("address not set up before write strobe");

  gate_in_write_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !pins_r.w_n |-> pins_r.oe_n)
    else $error("output gate low during write strobe");

  strobe_width_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $fell(pins_r.w_n) |-> !pins_r.w_n && dq_oe_r ##1 pins_r.w_n && dq_oe_r ##1 !dq_oe_r)
    else $error("write strobe or data hold wrong length");

  idle_deselect_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (state_r == ASBA_IDLE) |-> pins_r.s_n && !dq_oe_r)
    else $error("memory enabled while idle");

  no_contend_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    dq_oe_r |-> pins_r.oe_n && !pins_r.s_n)
    else $error("data driven while memory may drive");

  turn_gap_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $rose(pins_r.oe_n) |-> !dq_oe_r ##1 !dq_oe_r ##1 !dq_oe_r)
    else $error("bus turnaround too short");

  read_latency_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (req_ready && req_valid && !req.we) |-> ##[5:8] rd_valid_r)
    else $error("read answer out of window");

  write_latency_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (req_ready && req_valid && req.we) |-> ##4 wr_done_r)
    else $error("write completion late or early");
endmodule // asba_ctrl

// >>> core/asba_pkg.sv
package asba_pkg;
  localparam int ASBA_AW = 19;
  localparam int ASBA_DW = 8;
  localparam int ASBA_DEPTH = 524288;
  localparam int ASBA_CLK_KHZ = 20000;
  localparam int ASBA_SYNC_STAGES = 3;
  localparam int ASBA_CW = 3;

  // Memory timing in ns
  localparam int ASBA_T_ACC_NS = 55;
  localparam int ASBA_T_WP_NS = 40;
  localparam int ASBA_T_AWH_NS = 50;
  localparam int ASBA_T_DIS_NS = 20;

  // Least times round up to whole clock cycles, never below one
  localparam int ASBA_ACC_CYC = ((ASBA_T_ACC_NS * ASBA_CLK_KHZ + 999999) / 1000000 < 1) ? 1 :
    (ASBA_T_ACC_NS * ASBA_CLK_KHZ + 999999) / 1000000;
  localparam int ASBA_WP_RAW = (ASBA_T_WP_NS > ASBA_T_AWH_NS) ? ASBA_T_WP_NS : ASBA_T_AWH_NS;
  localparam int ASBA_WP_CYC = ((ASBA_WP_RAW * ASBA_CLK_KHZ + 999999) / 1000000 < 1) ? 1 :
    (ASBA_WP_RAW * ASBA_CLK_KHZ + 999999) / 1000000;
  localparam int ASBA_DIS_CYC = ((ASBA_T_DIS_NS * ASBA_CLK_KHZ + 999999) / 1000000 < 1) ? 1 :
    (ASBA_T_DIS_NS * ASBA_CLK_KHZ + 999999) / 1000000;
  // Access time plus the input synchroniser depth
  localparam logic [ASBA_CW-1:0] ASBA_RD_WAIT = ASBA_CW'(ASBA_ACC_CYC + ASBA_SYNC_STAGES - 1);
  localparam logic [ASBA_CW-1:0] ASBA_WP_LOAD = ASBA_CW'(ASBA_WP_CYC - 1);
  localparam logic [ASBA_CW-1:0] ASBA_DIS_LOAD = ASBA_CW'(ASBA_DIS_CYC - 1);

  localparam logic [ASBA_AW-1:0] ASBA_ADDR_RST = 19'h0_0000;
  localparam logic [ASBA_DW-1:0] ASBA_DATA_RST = 8'h00;

  typedef struct packed {
    logic we;
    logic [ASBA_AW-1:0] addr;
    logic [ASBA_DW-1:0] wdata;
  } asba_req_t;

  typedef struct packed {
    logic [ASBA_AW-1:0] addr;
    logic s_n;
    logic w_n;
    logic oe_n;
  } asba_pins_t;

  localparam asba_pins_t ASBA_PINS_IDLE = '{addr: ASBA_ADDR_RST, s_n: 1'b1, w_n: 1'b1, oe_n: 1'b1};

  typedef enum logic [2:0] {
    ASBA_IDLE = 3'b000,
    ASBA_WSET = 3'b001,
    ASBA_WPULSE = 3'b010,
    ASBA_WHOLD = 3'b011,
    ASBA_RACC = 3'b100,
    ASBA_RCAP = 3'b101,
    ASBA_TURN = 3'b110
  } asba_state_t;
endpackage

// >>> core/asba_sync.sv
`timescale 1ns/1ps
module asba_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [asba_pkg::ASBA_DW-1:0] din,
  output logic [asba_pkg::ASBA_DW-1:0] dout,
  output logic stable
);
  import asba_pkg::*;

  logic [ASBA_DW-1:0] s1_r;
  logic [ASBA_DW-1:0] s2_r;
  logic [ASBA_DW-1:0] s3_r;
  logic [ASBA_DW-1:0] agree;

  genvar i;
  generate
    for (i = 0; i < ASBA_DW; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
        end
      end
      assign agree[i] = (s2_r[i] == s3_r[i]);
    end
  endgenerate

  assign dout = s3_r;
  assign stable = &agree;
endmodule // asba_sync

// >>> dv/asba_mem_model.sv
`timescale 1ns/1ps
module asba_mem_model #(
  parameter int ACC_NS = 55
) (
  input wire asba_pkg::asba_pins_t pins,
  input wire logic [asba_pkg::ASBA_DW-1:0] dq_in,
  output logic [asba_pkg::ASBA_DW-1:0] dq_out,
  output logic dq_drive
);
  import asba_pkg::*;
  logic [ASBA_DW-1:0] cells [ASBA_DEPTH];
  logic wr_on = 1'b0;
  logic s_prev = 1'b1;
  logic rd_block = 1'b0;
  wire rd_ok;
  always @(pins.s_n or pins.w_n) begin
    if (wr_on && (pins.s_n || pins.w_n)) cells[pins.addr] = dq_in;
    if (pins.s_n) rd_block = 1'b0;
    else if (s_prev) rd_block = !pins.w_n;
    s_prev = pins.s_n;
    wr_on = !pins.s_n && !pins.w_n;
  end
  assign dq_drive = !pins.s_n && pins.w_n && !pins.oe_n && !rd_block;
  assign #(ACC_NS) rd_ok = dq_drive;
  // Wrong byte until the access time has run out
  assign dq_out = (rd_ok && dq_drive) ? cells[pins.addr] : ~cells[pins.addr];
endmodule // asba_mem_model

// >>> dv/test_async_sram_byte_array.sv
`timescale 1ns/1ps
module test_async_sram_byte_array;
  import asba_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  asba_req_t req = '0;
  logic req_ready, rd_valid, wr_done, dq_oe, mem_drive;
  logic [ASBA_DW-1:0] rd_data, dq_o, dq_i, mem_q;
  logic [ASBA_DW-1:0] float_pat = 8'h5a;
  logic [ASBA_AW-1:0] cur_addr = '0;
  asba_pins_t pins;
  logic [ASBA_DW-1:0] shadow [int];
  logic [ASBA_AW-1:0] used [$];
  logic [31:0] seed = 32'h0000_0012;
  int err_count = 0;
  int samples_checked = 0;

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) float_pat <= ~float_pat;
  assign dq_i = dq_oe ? dq_o : (mem_drive ? mem_q : float_pat);

  asba_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done), .pins(pins), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i));
  asba_mem_model u_mem (.pins(pins), .dq_in(dq_i), .dq_out(mem_q), .dq_drive(mem_drive));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Bus watch: no contention, no drive against the gate, address held while selected
  always @(negedge core_clk) begin
    if (rst_n) begin
      check({dq_oe & mem_drive, dq_oe & ~pins.oe_n}, 32'h0);
      if (!pins.s_n) check(pins.addr, cur_addr);
    end
  end

  task automatic op(input logic we, input logic [ASBA_AW-1:0] a, input logic [ASBA_DW-1:0] d);
    int n;
    int w;
    @(negedge core_clk);
    cur_addr = a;
    req = '{we: we, addr: a, wdata: d};
    req_valid = 1'b1;
    w = 0;
    while (req_ready !== 1'b1 && w < 20) begin
      @(negedge core_clk);
      w++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 1;
    while ((we ? wr_done : rd_valid) !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    if (w >= 20 || n >= 12) begin
      // A wait that ran out of its bound ends the run as a failure
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, w + n, 0);
      wrap_up();
    end else begin
      check(n >= (we ? 4 : 6) && n <= (we ? 5 : 9), 1);
      if (we) begin
        shadow[a] = d;
        used.push_back(a);
      end else begin
        check(rd_data, shadow[a]);
      end
    end
  endtask

  initial begin
    logic [ASBA_AW-1:0] a;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check({pins, dq_oe, mem_drive, req_ready, rd_valid, wr_done}, {ASBA_PINS_IDLE, 2'b00, 3'b100});
    check({dq_o, rd_data}, {ASBA_DATA_RST, ASBA_DATA_RST});
    $display("test reset done");
    op(1'b1, 19'h0_0000, 8'ha5);
    op(1'b1, 19'h7_ffff, 8'h5a);
    op(1'b1, 19'h0_0000, 8'h3c);
    op(1'b0, 19'h7_ffff, 8'h00);
    op(1'b0, 19'h0_0000, 8'h00);
    op(1'b0, 19'h0_0000, 8'h00);
    $display("test corners done");
    repeat (60) begin
      seed = xs(seed);
      if (seed[31] || used.size() == 0) op(1'b1, seed[18:0], seed[26:19]);
      else begin
        a = used[seed[15:0] % used.size()];
        op(1'b0, a, 8'h00);
      end
    end
    $display("test random done");
    repeat (400) @(negedge core_clk);
    foreach (used[i]) op(1'b0, used[i], 8'h00);
    $display("test retention done");
    wrap_up();
  end
endmodule // test_async_sram_byte_array
